// file: logic/pfs_status_bank.sv
// Fault status bank of a multi-rail power manager: power-good status,
// shutdown cause flags and per-rail voltage and current event flags.
// Assumes the serial management engine presents single-cycle register
// read and write strobes synchronous to clk, and that fault inputs are
// synchronous one-cycle or level detections from the analog monitors.
`timescale 1ns/1ps
`default_nettype none
module pfs_status_bank
    import pfs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [PFS_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [PFS_DATA_W-1:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [PFS_DATA_W-1:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic ext_reg_one_good,
    input wire logic ext_reg_two_good,
    input wire logic ext_reg_three_good,
    input wire logic over_temp_shutdown,
    input wire logic power_disable_input,
    input wire logic [PFS_VOLT_N-1:0] overvoltage_event,
    input wire logic [PFS_VOLT_N-1:0] undervoltage_event,
    input wire logic [PFS_OC_N-1:0] overcurrent_event
);
    logic rst_meta_reg;
    logic rst_sync_n;
    logic [2:0] ext_good_reg;
    logic [PFS_MISC_N-1:0] misc_clr;
    logic [PFS_VOLT_N-1:0] ov_clr;
    logic [PFS_VOLT_N-1:0] uv_clr;
    logic [PFS_OC_N-1:0] oc_clr;
    logic [PFS_MISC_N-1:0] misc_flags;
    logic [PFS_VOLT_N-1:0] ov_flags;
    logic [PFS_VOLT_N-1:0] uv_flags;
    logic [PFS_OC_N-1:0] oc_flags;
    logic [PFS_DATA_W-1:0] rd_data_next;

    // Reset is released through two flip-flops so every flag leaves
    // reset on the same edge.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    // Power-good is live status, not latched; it follows the inputs
    // with one cycle of delay.
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ext_good_reg <= 3'h0;
        end
        else
        begin
            ext_good_reg[PFS_EXT_ONE_BIT] <= ext_reg_one_good;
            ext_good_reg[PFS_EXT_TWO_BIT] <= ext_reg_two_good;
            ext_good_reg[PFS_EXT_THREE_BIT] <= ext_reg_three_good;
        end
    end

    // Clear strobes come only from writes to the clear registers; a write
    // to a flag register decodes to nothing and so is ignored.
    always_comb
    begin
        misc_clr = '0;
        ov_clr = '0;
        uv_clr = '0;
        oc_clr = '0;
        if (reg_wr_en)
        begin
            if (reg_addr == PFS_OFS_MISC_CLR)
            begin
                misc_clr = reg_wr_data[PFS_OTP_BIT:PFS_POWER_DISABLE_INPUT_BIT];
            end
            if (reg_addr == PFS_OFS_OV_CLR)
            begin
                ov_clr = reg_wr_data[PFS_VOLT_LSB +: PFS_VOLT_N];
            end
            if (reg_addr == PFS_OFS_UV_CLR)
            begin
                uv_clr = reg_wr_data[PFS_VOLT_LSB +: PFS_VOLT_N];
            end
            if (reg_addr == PFS_OFS_OC_CLR)
            begin
                oc_clr = reg_wr_data[PFS_OC_LSB +: PFS_OC_N];
            end
        end
    end

    // Sticky flag groups; bit 1 of misc is over-temperature, bit 0 is
    // the power-disable shutdown.
    pfs_flag_bits #(.WIDTH(PFS_MISC_N)) misc_cells
    (
        .clk(clk),
        .reset_n(rst_sync_n),
        .set_in({over_temp_shutdown, power_disable_input}),
        .clr_in(misc_clr),
        .flags(misc_flags)
    );

    pfs_flag_bits #(.WIDTH(PFS_VOLT_N)) ov_cells
    (
        .clk(clk),
        .reset_n(rst_sync_n),
        .set_in(overvoltage_event),
        .clr_in(ov_clr),
        .flags(ov_flags)
    );

    pfs_flag_bits #(.WIDTH(PFS_VOLT_N)) uv_cells
    (
        .clk(clk),
        .reset_n(rst_sync_n),
        .set_in(undervoltage_event),
        .clr_in(uv_clr),
        .flags(uv_flags)
    );

    pfs_flag_bits #(.WIDTH(PFS_OC_N)) oc_cells
    (
        .clk(clk),
        .reset_n(rst_sync_n),
        .set_in(overcurrent_event),
        .clr_in(oc_clr),
        .flags(oc_flags)
    );

    // Read multiplexer; reserved bits and clear registers read as zero.
    always_comb
    begin
        rd_data_next = PFS_UNMAPPED_BYTE;
        unique case (reg_addr)
            PFS_OFS_EXT_GOOD:
            begin
                rd_data_next = {5'h00, ext_good_reg};
            end
            PFS_OFS_MISC_FLAGS:
            begin
                rd_data_next = {misc_flags, 6'h00};
            end
            PFS_OFS_OV_FLAGS:
            begin
                rd_data_next = {ov_flags, 1'b0};
            end
            PFS_OFS_UV_FLAGS:
            begin
                rd_data_next = {uv_flags, 1'b0};
            end
            PFS_OFS_OC_FLAGS:
            begin
                rd_data_next = {1'b0, oc_flags, 2'h0};
            end
            default:
            begin
                rd_data_next = PFS_UNMAPPED_BYTE;
            end
        endcase
    end

    // Read answer is registered; data holds until the next read.
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            reg_rd_data <= PFS_RESET_BYTE;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
            begin
                reg_rd_data <= rd_data_next;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_n);

    // A write to address a with data bit b set, in one cycle.
    sequence clr_write(logic [7:0] a, int unsigned b);
        reg_wr_en && reg_addr == a && reg_wr_data[b];
    endsequence

    // A read of address a answered one cycle later.
    sequence read_of(logic [7:0] a);
        reg_rd_en && reg_addr == a;
    endsequence

    // The answer stands one cycle after the read strobe and shows the
    // levels sampled into the status flops on the edge before it.
    pg_report_a: assert property (
        read_of(PFS_OFS_EXT_GOOD) |=> reg_rd_valid
            && reg_rd_data == {5'h00, $past(ext_reg_one_good, 2),
            $past(ext_reg_two_good, 2), $past(ext_reg_three_good, 2)})
        else $error("power-good read does not match inputs");

    otp_set_a: assert property (
        over_temp_shutdown ##1 read_of(PFS_OFS_MISC_FLAGS)
            |=> reg_rd_data[PFS_OTP_BIT])
        else $error("over-temperature flag not reported");

    power_disable_input_set_a: assert property (
        power_disable_input |=> misc_flags[0] [*1])
        else $error("power-disable flag not set");

    ov_map_a: assert property (
        overvoltage_event[PFS_VOLT_N-1] ##1 read_of(PFS_OFS_OV_FLAGS)
            |=> reg_rd_data[7])
        else $error("input overvoltage not at bit 7");

    uv_map_a: assert property (
        undervoltage_event[0] ##1 read_of(PFS_OFS_UV_FLAGS)
            |=> reg_rd_data[PFS_VOLT_LSB])
        else $error("linear undervoltage not at bit 1");

    oc_rsvd_a: assert property (
        read_of(PFS_OFS_OC_FLAGS)
            |=> reg_rd_data[7] == 1'b0 && reg_rd_data[1:0] == 2'h0
            && reg_rd_data[6:2] == $past(oc_flags))
        else $error("overcurrent register layout wrong");

    misc_clear_a: assert property (
        clr_write(PFS_OFS_MISC_CLR, PFS_OTP_BIT) && !over_temp_shutdown
            |=> !misc_flags[1])
        else $error("over-temperature flag not cleared");

    ov_clear_a: assert property (
        clr_write(PFS_OFS_OV_CLR, 7) && !overvoltage_event[6]
            |=> !ov_flags[6])
        else $error("input overvoltage flag not cleared");

    flag_hold_a: assert property (
        ov_flags[0] && !(reg_wr_en && reg_addr == PFS_OFS_OV_CLR)
            |=> ov_flags[0])
        else $error("overvoltage flag dropped without clear");

    set_wins_a: assert property (
        clr_write(PFS_OFS_UV_CLR, 7) && undervoltage_event[6]
            |=> uv_flags[6] ##1 (uv_flags[6] || $past(reg_wr_en)))
        else $error("event lost against simultaneous clear");
endmodule
`default_nettype wire

// file: logic/pfs_pkg.sv
// Package for the power-manager fault status bank.
// Holds register offsets, field positions and reset values shared by
// the bank and its sticky flag cells.
`default_nettype none
package pfs_pkg;
    // Widths of the internal register port.
    localparam int unsigned PFS_ADDR_W = 8;
    localparam int unsigned PFS_DATA_W = 8;

    // Status and flag registers.
    localparam logic [7:0] PFS_OFS_EXT_GOOD = 8'h07;
    localparam logic [7:0] PFS_OFS_MISC_FLAGS = 8'h08;
    localparam logic [7:0] PFS_OFS_OV_FLAGS = 8'h09;
    localparam logic [7:0] PFS_OFS_UV_FLAGS = 8'h0A;
    localparam logic [7:0] PFS_OFS_OC_FLAGS = 8'h0B;

    // Clear registers, each bit matching its flag register.
    localparam logic [7:0] PFS_OFS_MISC_CLR = 8'h0D;
    localparam logic [7:0] PFS_OFS_OV_CLR = 8'h0E;
    localparam logic [7:0] PFS_OFS_UV_CLR = 8'h0F;
    localparam logic [7:0] PFS_OFS_OC_CLR = 8'h10;

    // Field positions: external good bits 2..0, misc bits 7..6,
    // voltage flags 7..1, overcurrent flags 6..2.
    localparam int unsigned PFS_EXT_ONE_BIT = 2;
    localparam int unsigned PFS_EXT_TWO_BIT = 1;
    localparam int unsigned PFS_EXT_THREE_BIT = 0;
    localparam int unsigned PFS_OTP_BIT = 7;
    localparam int unsigned PFS_POWER_DISABLE_INPUT_BIT = 6;
    localparam int unsigned PFS_VOLT_LSB = 1;
    localparam int unsigned PFS_OC_LSB = 2;

    // Numbers of flags in each group.
    localparam int unsigned PFS_MISC_N = 2;
    localparam int unsigned PFS_VOLT_N = 7;
    localparam int unsigned PFS_OC_N = 5;

    // Values after reset and read from unmapped addresses.
    localparam logic [7:0] PFS_RESET_BYTE = 8'h00;
    localparam logic [7:0] PFS_UNMAPPED_BYTE = 8'h00;
endpackage
`default_nettype wire

// file: logic/pfs_flag_bits.sv
// Group of sticky event flags with per-bit clear.
// Assumes set and clear inputs are synchronous to clk and reset_n is
// already synchronised by the caller.
`timescale 1ns/1ps
`default_nettype none
module pfs_flag_bits
    import pfs_pkg::*;
#(
    parameter int unsigned WIDTH = 7
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    output logic [WIDTH-1:0] flags
);
    // A set in the same cycle as its clear wins, so no event is lost.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flags <= '0;
        end
        else
        begin
            flags <= (flags & ~clr_in) | set_in;
        end
    end
endmodule
`default_nettype wire

// file: test/pfs_host_model.sv
// Host-side model that drives the bank's internal register port.
// Assumes a free-running clk; every request starts 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pfs_host_model
    import pfs_pkg::*;
(
    input wire logic clk,
    output logic [PFS_ADDR_W-1:0] reg_addr,
    output logic reg_wr_en,
    output logic [PFS_DATA_W-1:0] reg_wr_data,
    output logic reg_rd_en,
    input wire logic [PFS_DATA_W-1:0] reg_rd_data,
    input wire logic reg_rd_valid
);
    // Idle port state from time zero.
    initial
    begin
        reg_addr = 8'hFF;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end

    // Flags are only ever cleared through the clear registers.
    // Address and data are inverted after the strobe so that nothing can
    // lean on a stale value left on the port.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        reg_addr = addr;
        reg_wr_data = data;
        reg_wr_en = 1'b1;
        @(posedge clk);
        #1;
        reg_wr_en = 1'b0;
        reg_addr = ~addr;
        reg_wr_data = ~data;
    endtask

    // One read strobe; the answer is registered, so it is taken one cycle on.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data,
        output logic valid);
        @(posedge clk);
        #1;
        reg_addr = addr;
        reg_rd_en = 1'b1;
        @(posedge clk);
        #1;
        data = reg_rd_data;
        valid = reg_rd_valid;
        reg_rd_en = 1'b0;
        reg_addr = ~addr;
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the fault status bank.
// Assumes the host model drives the register port and the bench the monitors.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pfs_pkg::*;
    logic clk;
    logic reset_n;
    logic [2:0] good;
    logic [20:0] ev;
    logic [7:0] addr;
    logic wr_en;
    logic [7:0] wr_data;
    logic rd_en;
    logic [7:0] rd_data;
    logic rd_valid;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    pfs_status_bank dut (.clk(clk), .reset_n(reset_n), .reg_addr(addr),
        .reg_wr_en(wr_en), .reg_wr_data(wr_data), .reg_rd_en(rd_en),
        .reg_rd_data(rd_data), .reg_rd_valid(rd_valid),
        .ext_reg_one_good(good[2]), .ext_reg_two_good(good[1]),
        .ext_reg_three_good(good[0]), .over_temp_shutdown(ev[20]),
        .power_disable_input(ev[19]), .overvoltage_event(ev[18:12]),
        .undervoltage_event(ev[11:5]), .overcurrent_event(ev[4:0]));

    pfs_host_model host (.clk(clk), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_wr_data(wr_data), .reg_rd_en(rd_en), .reg_rd_data(rd_data),
        .reg_rd_valid(rd_valid));

    // 50 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cuts a hang short; the tests need well under a thousand cycles.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            bad_count++;
            end_sim();
        end
    end

    task automatic end_sim;
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Reads one register and checks both the answer marker and the value.
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        chk("read valid", 8'h01, {7'h00, v});
        chk($sformatf("register %h", a), exp, d);
    endtask

    // Holds the given monitor events for exactly one cycle.
    task automatic pulse(input logic [20:0] e);
        @(posedge clk);
        #1;
        ev = e;
        @(posedge clk);
        #1;
        ev = 21'h000000;
    endtask

    // Event pulse with a read strobe on the very next edge, so the flag is
    // reported in the first cycle it can be.
    task automatic pulse_rd(input logic [20:0] e, input logic [7:0] a,
        input logic [7:0] exp);
        fork
            pulse(e);
            begin
                @(posedge clk);
                rdchk(a, exp);
            end
        join
    endtask

    // A clear and an event on the same flag in one cycle: the event wins.
    task automatic test_race;
        fork
            host.wr(8'h0F, 8'h80);
            pulse(21'h000800);
        join
        rdchk(8'h0A, 8'h80);
        host.wr(8'h0F, 8'h80);
        rdchk(8'h0A, 8'h00);
    endtask

    // Every flag and clear register reads zero out of reset, as does the hole at 0x20.
    task automatic test_reset;
        for (int a = 7; a <= 16; a++)
            if (a != 12)
                rdchk(a[7:0], 8'h00);
        rdchk(8'h20, 8'h00);
    endtask

    // Every combination of the three good levels, plus an ignored write.
    task automatic test_good;
        for (int i = 0; i < 8; i++)
        begin
            good = i[2:0];
            rdchk(8'h07, {5'h00, i[2:0]});
        end
        host.wr(8'h07, 8'h00);
        rdchk(8'h07, 8'h07);
        good = 3'h0;
    endtask

    // Shutdown causes latch, ignore writes and clear one at a time.
    task automatic test_misc;
        pulse_rd(21'h100000, 8'h08, 8'h80);
        host.wr(8'h08, 8'h00);
        rdchk(8'h08, 8'h80);
        pulse(21'h080000);
        rdchk(8'h08, 8'hC0);
        host.wr(8'h0D, 8'h80);
        rdchk(8'h08, 8'h40);
        host.wr(8'h0D, 8'h40);
        rdchk(8'h08, 8'h00);
    endtask

    // Each voltage monitor bit lands in its own flag bit of both registers.
    // The linear regulator bit is read from the undervoltage side first,
    // the others from the overvoltage side first.
    task automatic test_volt;
        logic [7:0] exp;
        logic [20:0] e;
        for (int i = 0; i < 7; i++)
        begin
            exp = 8'h02 << i;
            e = (21'h001000 << i) | (21'h000020 << i);
            if (i == 0)
            begin
                pulse_rd(e, 8'h0A, exp);
                rdchk(8'h09, exp);
            end
            else
            begin
                pulse_rd(e, 8'h09, exp);
                rdchk(8'h0A, exp);
            end
            host.wr(8'h09, 8'h00);
            host.wr(8'h0E, exp);
            rdchk(8'h09, 8'h00);
            rdchk(8'h0A, exp);
            host.wr(8'h0F, exp);
            rdchk(8'h0A, 8'h00);
        end
    endtask

    // Overcurrent uses bits 6..2 only; the rest stay zero.
    task automatic test_oc;
        logic [7:0] exp;
        for (int i = 0; i < 5; i++)
        begin
            exp = 8'h04 << i;
            pulse(21'h000001 << i);
            rdchk(8'h0B, exp);
            host.wr(8'h10, exp);
            rdchk(8'h0B, 8'h00);
        end
    endtask

    // Main sequence: reset for 10 cycles, settle, then the scenarios.
    initial
    begin
        reset_n = 1'b0;
        good = 3'h0;
        ev = 21'h000000;
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge clk);
        test_reset();
        test_good();
        test_misc();
        test_volt();
        test_oc();
        test_race();
        end_sim();
    end
endmodule
`default_nettype wire
